// ==== rtl/pdsc_core.sv ====
// Purpose: supervision and configuration of a turbopump drive
// Assumes: analog values come as codes from converters on core_clk
// Notes: speeds, powers and set values are in tenths of a percent, except the power limit set value in whole percent
//
// How it works
// - digital input selector routes pin to control bit
// - analog output source chosen by codes 0-8
// - follow option copies analog input one out
// - analog input code 1 gives set speed in setting mode
// - one-hot code picks the controlling interface
// - lock bit freezes the interface selection
// - gas mode picks one of three power limits
// - full power in run-up, then gas limit
// - overload lowers speed until power balances
// - power limit follows percentage set value
// - run-up longer than limit raises error
// - switchpoint crossing drives output and flag
// - mode 0 uses switchpoint one only
// - mode 1 switches point by pumping station
// - setting mode value wins, standby ignored
// - setting mode scales switchpoint by set speed
// - attained flag follows actual versus set speed in setting or standby mode
// - too low set value warns and clamps
// - standby reduces speed, default 66.7 percent
//
// Our own choices: the placing of the registers and the address-and-strobe port.
module pdsc_core #(
    parameter int ADC_W = 10,
    parameter int NUM_DI = 3,
    parameter logic [9:0] MIN_SPEED = 10'h0C8,
    parameter logic [9:0] SPEED_TOL = 10'h005,
    parameter logic [9:0] GAS0_MAX = 10'h3E8,
    parameter logic [9:0] GAS1_MAX = 10'h352,
    parameter logic [9:0] GAS2_MAX = 10'h2BC,
    parameter int SEC_CYCLES = pdsc_pkg::SEC_CYC,
    parameter int ADJ_CYCLES = pdsc_pkg::ADJ_CYC
) (
    input wire logic core_clk, // 200 MHz clock
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] reg_addr, // register index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    input wire logic [NUM_DI-1:0] remote_din, // remote digital pins
    input wire logic [ADC_W-1:0] analog_input_one, // analog input code
    input wire logic [9:0] actual_speed, // measured speed
    input wire logic [9:0] power_in, // measured power
    input wire logic [9:0] current_in, // measured current
    input wire logic [ADC_W-1:0] pressure_one, // gauge 1 code
    input wire logic [ADC_W-1:0] pressure_two, // gauge 2 code
    input wire logic [ADC_W-1:0] forevac_ctrl, // fore-vacuum code
    output logic [ADC_W-1:0] analog_out, // analog output code
    output logic [9:0] speed_cmd, // speed command to drive
    output logic [9:0] power_limit, // power ceiling to drive
    output logic [4:0] active_interface, // one-hot control source
    output logic switchpoint_out, // switchpoint signal output
    output logic set_speed_attained_flag, // set speed reached
    output logic speed_range_warning, // set value clamped
    output logic runup_error, // run-up took too long
    output logic [pdsc_pkg::CTRL_W:0] ctrl_out // effective control bits
);
    localparam int CTRL_OUT_W = pdsc_pkg::CTRL_W + 1;
    localparam logic [ADC_W-1:0] ADC_MAX = {ADC_W{1'b1}};

    initial begin
        if (ADC_W < 8 || ADC_W > 12 || NUM_DI < 1 || NUM_DI > 3)
            $error("pdsc_core: unsupported ADC_W or NUM_DI");
        if (SEC_CYCLES < 2 || ADJ_CYCLES < 2)
            $error("pdsc_core: tick counts too small");
    end

    typedef struct packed {
        logic [NUM_DI-1:0] din_s1;
        logic [NUM_DI-1:0] din_s2;
        logic [11:0] di_func;
        logic [3:0] ao_src;
        logic ai_sel;
        logic [4:0] if_sel;
        logic if_lock;
        logic [1:0] gas_mode;
        logic [6:0] pwr_pct;
        logic [15:0] runup_lim;
        logic [9:0] swpt1;
        logic [9:0] swpt2;
        logic swpt_mode;
        logic [9:0] setmode_val;
        logic [9:0] standby_val;
        logic [pdsc_pkg::CTRL_W-1:0] ctrl;
        logic hv_rel;
        logic [31:0] sec_cnt;
        logic [31:0] adj_cnt;
        logic [15:0] runup_secs;
        logic runup;
        logic [9:0] speed_cmd;
        logic [9:0] power_limit;
        logic [ADC_W-1:0] analog_out;
        logic switchpoint;
        logic attained;
        logic warning;
        logic runup_err;
        logic [CTRL_OUT_W-1:0] ctrl_out;
        logic [15:0] rdata;
    } pdsc_state_t;

    pdsc_state_t s_q, s_d;

    // product of two tenth-percent values, back in tenths
    function automatic logic [9:0] pdsc_pm_mul(input logic [9:0] a,
                                               input logic [9:0] b);
        logic [19:0] p;
        p = 20'(a) * 20'(b) / 20'h003E8;
        return (p > 20'h003E8) ? pdsc_pkg::PM_FULL : p[9:0];
    endfunction

    // tenth-percent value to a full-scale converter code
    function automatic logic [ADC_W-1:0] pdsc_to_code(input logic [9:0] v);
        logic [23:0] p;
        p = 24'(v) * 24'(ADC_MAX) / 24'h0003E8;
        return p[ADC_W-1:0];
    endfunction

    // ----------------------------------------------------------------
    // combinational next state
    // ----------------------------------------------------------------
    logic [NUM_DI-1:0] din;
    logic [pdsc_pkg::CTRL_W-1:0] eff;
    logic hv_eff;
    logic hv_assigned;
    logic [2:0] fn;
    logic [9:0] ai_pm;
    logic [9:0] target;
    logic [9:0] clamped;
    logic [9:0] gas_max;
    logic [9:0] limit;
    logic [9:0] base;
    logic [9:0] thresh;
    logic [9:0] diff;
    logic [23:0] ai_wide;
    logic sec_tick;
    logic adj_tick;
    logic reduced;

    always_comb begin
        s_d = s_q;
        din = s_q.din_s2;
        eff = s_q.ctrl;
        hv_eff = s_q.hv_rel;
        hv_assigned = 1'b0;
        fn = 3'h0;
        // pin synchroniser, first stage read only by second
        s_d.din_s1 = remote_din;
        s_d.din_s2 = s_q.din_s1;
        // assigned pins drive the matching control bit
        for (int i = 0; i < NUM_DI; i++) begin
            fn = s_q.di_func[i*pdsc_pkg::DI_FUNC_STRIDE +: 3];
            case (fn)
                pdsc_pkg::DI_VENT: eff[pdsc_pkg::CTRL_VENT] = din[i];
                pdsc_pkg::DI_HEAT: eff[pdsc_pkg::CTRL_HEAT] = din[i];
                pdsc_pkg::DI_SEAL: eff[pdsc_pkg::CTRL_SEAL] = din[i];
                pdsc_pkg::DI_RUNUP: eff[pdsc_pkg::CTRL_RUNUP] = din[i];
                pdsc_pkg::DI_SETMODE: eff[pdsc_pkg::CTRL_SETMODE] = din[i];
                pdsc_pkg::DI_HV: begin
                    hv_eff = din[i];
                    hv_assigned = 1'b1;
                end
                default: ;
            endcase
        end
        s_d.ctrl_out = {hv_eff, eff};

        // register writes
        if (reg_we) begin
            case (reg_addr)
                pdsc_pkg::REG_DI_FUNC: s_d.di_func = reg_wdata[11:0];
                pdsc_pkg::REG_AO_SRC:
                    if (reg_wdata[3:0] <= pdsc_pkg::AO_FOREVAC)
                        s_d.ao_src = reg_wdata[3:0];
                pdsc_pkg::REG_AI_SEL: s_d.ai_sel = reg_wdata[0];
                pdsc_pkg::REG_IF_SEL: begin
                    // a locked selection only accepts the unlock
                    if (!s_q.if_lock && $onehot(reg_wdata[4:0]))
                        s_d.if_sel = reg_wdata[4:0];
                    s_d.if_lock = reg_wdata[pdsc_pkg::IF_LOCK_BIT];
                end
                pdsc_pkg::REG_GAS_MODE:
                    if (reg_wdata[1:0] != 2'h3)
                        s_d.gas_mode = reg_wdata[1:0];
                pdsc_pkg::REG_PWR_LIMIT:
                    if (reg_wdata[6:0] <= pdsc_pkg::PWR_LIMIT_RST)
                        s_d.pwr_pct = reg_wdata[6:0];
                pdsc_pkg::REG_RUNUP_TIME: s_d.runup_lim = reg_wdata;
                pdsc_pkg::REG_SWPT1: s_d.swpt1 = reg_wdata[9:0];
                pdsc_pkg::REG_SWPT2: s_d.swpt2 = reg_wdata[9:0];
                pdsc_pkg::REG_SWPT_MODE: s_d.swpt_mode = reg_wdata[0];
                pdsc_pkg::REG_SETMODE_VAL: s_d.setmode_val = reg_wdata[9:0];
                pdsc_pkg::REG_STANDBY_VAL: s_d.standby_val = reg_wdata[9:0];
                pdsc_pkg::REG_CTRL:
                    s_d.ctrl = reg_wdata[pdsc_pkg::CTRL_W-1:0];
                pdsc_pkg::REG_HV_RELEASE:
                    if (!hv_assigned || reg_wdata[15:1] == 15'h0000)
                        s_d.hv_rel = reg_wdata[0];
                default: ;
            endcase
        end

        // tick dividers for seconds and for speed adjustment steps
        sec_tick = (s_q.sec_cnt == 32'(SEC_CYCLES - 1));
        adj_tick = (s_q.adj_cnt == 32'(ADJ_CYCLES - 1));
        s_d.sec_cnt = sec_tick ? 32'h00000000 : s_q.sec_cnt + 32'h00000001;
        s_d.adj_cnt = adj_tick ? 32'h00000000 : s_q.adj_cnt + 32'h00000001;

        // set speed selection; settings act from the evaluation after their write
        ai_wide = 24'(analog_input_one) * 24'h0003E8 / 24'(ADC_MAX);
        ai_pm = ai_wide[9:0];
        if (eff[pdsc_pkg::CTRL_SETMODE]) begin
            target = s_q.ai_sel ? ai_pm : s_q.setmode_val;
        end else if (eff[pdsc_pkg::CTRL_STANDBY]) begin
            target = s_q.standby_val;
        end else begin
            target = pdsc_pkg::PM_FULL;
        end
        if (target > pdsc_pkg::PM_FULL)
            target = pdsc_pkg::PM_FULL;
        clamped = (target < MIN_SPEED) ? MIN_SPEED : target;
        s_d.warning = (eff[pdsc_pkg::CTRL_SETMODE] ||
                       eff[pdsc_pkg::CTRL_STANDBY]) && (target < MIN_SPEED);

        // gas mode characteristic and percentage power ceiling
        case (s_q.gas_mode)
            2'h1: gas_max = GAS1_MAX;
            2'h2: gas_max = GAS2_MAX;
            default: gas_max = GAS0_MAX;
        endcase
        base = s_q.runup ? pdsc_pkg::PM_FULL : gas_max;
        limit = pdsc_pm_mul(base, 10'(s_q.pwr_pct) * 10'h00A);
        s_d.power_limit = limit;

        // run-up ends once the set speed is first reached
        if (!eff[pdsc_pkg::CTRL_PUMP]) begin
            s_d.runup = 1'b0;
            s_d.runup_secs = 16'h0000;
            s_d.runup_err = 1'b0;
        end else if (!s_q.runup && s_q.runup_secs == 16'h0000 &&
                     actual_speed < clamped) begin
            s_d.runup = 1'b1;
        end else if (s_q.runup && actual_speed >= clamped) begin
            s_d.runup = 1'b0;
            s_d.runup_secs = 16'h0001;
        end
        if (s_q.runup && sec_tick && s_q.runup_secs != 16'hFFFF)
            s_d.runup_secs = s_q.runup_secs + 16'h0001;
        if (s_q.runup && eff[pdsc_pkg::CTRL_RUNUP] &&
            s_q.runup_secs > s_q.runup_lim)
            s_d.runup_err = 1'b1;

        // speed command trims down under overload, recovers after
        reduced = !s_q.runup && (power_in > limit);
        if (!eff[pdsc_pkg::CTRL_PUMP]) begin
            s_d.speed_cmd = 10'h000;
        end else if (s_q.runup || s_q.speed_cmd > clamped ||
                     s_q.speed_cmd < MIN_SPEED) begin
            s_d.speed_cmd = clamped;
        end else if (adj_tick) begin
            if (reduced && s_q.speed_cmd > MIN_SPEED)
                s_d.speed_cmd = s_q.speed_cmd - 10'h001;
            else if (!reduced && s_q.speed_cmd < clamped)
                s_d.speed_cmd = s_q.speed_cmd + 10'h001;
        end

        // active switchpoint, scaled by set speed in setting mode
        if (s_q.swpt_mode && !eff[pdsc_pkg::CTRL_PUMP])
            thresh = s_q.swpt2;
        else
            thresh = s_q.swpt1;
        if (eff[pdsc_pkg::CTRL_SETMODE])
            thresh = pdsc_pm_mul(thresh, clamped);
        s_d.switchpoint = (actual_speed >= thresh);

        // attained flag in setting or standby mode
        diff = (actual_speed > clamped) ? actual_speed - clamped :
                                          clamped - actual_speed;
        s_d.attained = (eff[pdsc_pkg::CTRL_SETMODE] ||
                        eff[pdsc_pkg::CTRL_STANDBY]) &&
                       (diff <= SPEED_TOL);

        // analog output source
        case (s_q.ao_src)
            pdsc_pkg::AO_SPEED: s_d.analog_out = pdsc_to_code(actual_speed);
            pdsc_pkg::AO_POWER: s_d.analog_out = pdsc_to_code(power_in);
            pdsc_pkg::AO_CURRENT: s_d.analog_out = pdsc_to_code(current_in);
            pdsc_pkg::AO_FULL: s_d.analog_out = ADC_MAX;
            pdsc_pkg::AO_FOLLOW: s_d.analog_out = analog_input_one;
            pdsc_pkg::AO_PRESS1: s_d.analog_out = pressure_one;
            pdsc_pkg::AO_PRESS2: s_d.analog_out = pressure_two;
            pdsc_pkg::AO_FOREVAC: s_d.analog_out = forevac_ctrl;
            default: s_d.analog_out = '0;
        endcase

        // read data, valid the cycle after the strobe only
        s_d.rdata = 16'h0000;
        if (reg_re) begin
            case (reg_addr)
                pdsc_pkg::REG_DI_FUNC: s_d.rdata = {4'h0, s_q.di_func};
                pdsc_pkg::REG_AO_SRC: s_d.rdata = {12'h000, s_q.ao_src};
                pdsc_pkg::REG_AI_SEL: s_d.rdata = {15'h0000, s_q.ai_sel};
                pdsc_pkg::REG_IF_SEL:
                    s_d.rdata = {7'h00, s_q.if_lock, 3'h0, s_q.if_sel};
                pdsc_pkg::REG_GAS_MODE: s_d.rdata = {14'h0000, s_q.gas_mode};
                pdsc_pkg::REG_PWR_LIMIT: s_d.rdata = {9'h000, s_q.pwr_pct};
                pdsc_pkg::REG_RUNUP_TIME: s_d.rdata = s_q.runup_lim;
                pdsc_pkg::REG_SWPT1: s_d.rdata = {6'h00, s_q.swpt1};
                pdsc_pkg::REG_SWPT2: s_d.rdata = {6'h00, s_q.swpt2};
                pdsc_pkg::REG_SWPT_MODE: s_d.rdata = {15'h0000, s_q.swpt_mode};
                pdsc_pkg::REG_SETMODE_VAL:
                    s_d.rdata = {6'h00, s_q.setmode_val};
                pdsc_pkg::REG_STANDBY_VAL:
                    s_d.rdata = {6'h00, s_q.standby_val};
                pdsc_pkg::REG_CTRL: s_d.rdata = {9'h000, s_q.ctrl};
                pdsc_pkg::REG_STATUS:
                    s_d.rdata = {10'h000, reduced, s_q.runup,
                                 s_q.runup_err, s_q.warning,
                                 s_q.attained, s_q.switchpoint};
                pdsc_pkg::REG_SET_SPEED: s_d.rdata = {6'h00, s_q.speed_cmd};
                pdsc_pkg::REG_HV_RELEASE: s_d.rdata = {15'h0000, hv_eff};
                default: s_d.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.if_sel <= pdsc_pkg::IF_SEL_RST;
            s_q.pwr_pct <= pdsc_pkg::PWR_LIMIT_RST;
            s_q.runup_lim <= pdsc_pkg::RUNUP_TIME_RST;
            s_q.swpt1 <= pdsc_pkg::SWPT1_RST;
            s_q.swpt2 <= pdsc_pkg::SWPT2_RST;
            s_q.setmode_val <= pdsc_pkg::PM_FULL;
            s_q.standby_val <= pdsc_pkg::STANDBY_RST;
            s_q.power_limit <= pdsc_pkg::PM_FULL;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s_q.rdata;
    assign analog_out = s_q.analog_out;
    assign speed_cmd = s_q.speed_cmd;
    assign power_limit = s_q.power_limit;
    assign active_interface = s_q.if_sel;
    assign switchpoint_out = s_q.switchpoint;
    assign set_speed_attained_flag = s_q.attained;
    assign speed_range_warning = s_q.warning;
    assign runup_error = s_q.runup_err;
    assign ctrl_out = s_q.ctrl_out;
endmodule

// ==== rtl/pdsc_pkg.sv ====
// Purpose: shared constants of the pump drive speed configuration block
// Assumes: 16-bit register port, word-indexed offsets
// Notes: percentages are held in tenths of a percent (1000 = 100 %), except the power limit in whole percent
package pdsc_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_DI_FUNC = 8'h00;
    localparam logic [7:0] REG_AO_SRC = 8'h01;
    localparam logic [7:0] REG_AI_SEL = 8'h02;
    localparam logic [7:0] REG_IF_SEL = 8'h03;
    localparam logic [7:0] REG_GAS_MODE = 8'h04;
    localparam logic [7:0] REG_PWR_LIMIT = 8'h05;
    localparam logic [7:0] REG_RUNUP_TIME = 8'h06;
    localparam logic [7:0] REG_SWPT1 = 8'h07;
    localparam logic [7:0] REG_SWPT2 = 8'h08;
    localparam logic [7:0] REG_SWPT_MODE = 8'h09;
    localparam logic [7:0] REG_SETMODE_VAL = 8'h0A;
    localparam logic [7:0] REG_STANDBY_VAL = 8'h0B;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h0D;
    localparam logic [7:0] REG_SET_SPEED = 8'h0E;
    localparam logic [7:0] REG_HV_RELEASE = 8'h0F;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DI_FUNC_W = 3;
    localparam int DI_FUNC_STRIDE = 4;
    localparam int IF_LOCK_BIT = 8;
    localparam int CTRL_PUMP = 0;
    localparam int CTRL_HEAT = 1;
    localparam int CTRL_SEAL = 2;
    localparam int CTRL_VENT = 3;
    localparam int CTRL_RUNUP = 4;
    localparam int CTRL_SETMODE = 5;
    localparam int CTRL_STANDBY = 6;
    localparam int CTRL_W = 7;
    // ----------------------------------------------------------------
    // selector codes
    // ----------------------------------------------------------------
    localparam logic [2:0] DI_OFF = 3'h0;
    localparam logic [2:0] DI_VENT = 3'h1;
    localparam logic [2:0] DI_HEAT = 3'h2;
    localparam logic [2:0] DI_SEAL = 3'h3;
    localparam logic [2:0] DI_RUNUP = 3'h4;
    localparam logic [2:0] DI_SETMODE = 3'h5;
    localparam logic [2:0] DI_HV = 3'h7;
    localparam logic [3:0] AO_SPEED = 4'h0;
    localparam logic [3:0] AO_POWER = 4'h1;
    localparam logic [3:0] AO_CURRENT = 4'h2;
    localparam logic [3:0] AO_ZERO = 4'h3;
    localparam logic [3:0] AO_FULL = 4'h4;
    localparam logic [3:0] AO_FOLLOW = 4'h5;
    localparam logic [3:0] AO_PRESS1 = 4'h6;
    localparam logic [3:0] AO_PRESS2 = 4'h7;
    localparam logic [3:0] AO_FOREVAC = 4'h8;
    localparam logic [4:0] IF_REMOTE = 5'h01;
    localparam logic [4:0] IF_SERIAL = 5'h02;
    localparam logic [4:0] IF_SERVICE = 5'h04;
    localparam logic [4:0] IF_FIELDBUS = 5'h08;
    localparam logic [4:0] IF_AUX = 5'h10;
    // ----------------------------------------------------------------
    // reset values and scales
    // ----------------------------------------------------------------
    localparam logic [9:0] PM_FULL = 10'h3E8;
    localparam logic [9:0] STANDBY_RST = 10'h29B;
    localparam logic [9:0] SWPT1_RST = 10'h320;
    localparam logic [9:0] SWPT2_RST = 10'h320;
    localparam logic [6:0] PWR_LIMIT_RST = 7'h64;
    localparam logic [15:0] RUNUP_TIME_RST = 16'h01E0;
    localparam logic [4:0] IF_SEL_RST = 5'h01;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 5;
    localparam int SEC_NS = 1000000000;
    localparam int ADJ_NS = 1000000;
    localparam int SEC_CYC = SEC_NS / CLK_NS;
    localparam int ADJ_CYC = ADJ_NS / CLK_NS;
endpackage

// ==== verification/pdsc_chk.sv ====
// Purpose: port assertions for the pump drive speed configuration
// Assumes: one clock, resetn asynchronous and active low
// Notes: ctrl_out is taken as eight bits wide
module pdsc_chk #(
    parameter logic [9:0] MIN_SPEED = 10'h0C8,
    parameter logic [9:0] SPEED_TOL = 10'h005
) (
    input wire logic core_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic reg_we, // write strobe
    input wire logic [9:0] speed_cmd, // speed command
    input wire logic [9:0] actual_speed, // rotor speed
    input wire logic [9:0] power_limit, // power ceiling
    input wire logic [4:0] active_interface, // control source
    input wire logic set_speed_attained_flag, // set speed reached
    input wire logic speed_range_warning, // clamp warning
    input wire logic runup_error, // run-up too long
    input wire logic [7:0] ctrl_out // effective control bits
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // distance between rotor and command
    logic [9:0] gap;
    assign gap = (actual_speed > speed_cmd) ? actual_speed - speed_cmd
                                            : speed_cmd - actual_speed;
    // interface moves only just after a register write
    sequence s_after_wr;
        $past(reg_we) || $past(reg_we, 2);
    endsequence
    // pumping bit drops close to the error clearing
    sequence s_pump_drop;
        ##[0:2] !ctrl_out[0];
    endsequence
    a_iface_one_hot: assert property ($onehot(active_interface))
        else $error("interface not one-hot");
    a_iface_by_write: assert property ($changed(active_interface)
        |-> s_after_wr) else $error("interface moved without write");
    a_power_ceiling: assert property (power_limit <= 10'h3E8)
        else $error("power ceiling above full");
    a_attain_near: assert property (set_speed_attained_flag
        |-> gap <= SPEED_TOL + 10'h003) else $error("attained too far");
    a_runup_sticky: assert property ($fell(runup_error)
        |-> s_pump_drop) else $error("run-up error cleared early");
    a_pump_off_zero: assert property (!ctrl_out[0]
        && !$past(ctrl_out[0]) |-> speed_cmd == 10'h000)
        else $error("speed command while off");
    a_warn_clamped: assert property (speed_range_warning
        && ctrl_out[0] |-> speed_cmd == MIN_SPEED)
        else $error("warning without clamp");
    a_speed_floor: assert property (speed_cmd != 10'h000
        |-> speed_cmd >= MIN_SPEED) else $error("speed below floor");
endmodule
bind pdsc_core pdsc_chk #(.MIN_SPEED(MIN_SPEED), .SPEED_TOL(SPEED_TOL))
    u_chk (.core_clk(core_clk), .resetn(resetn), .reg_we(reg_we),
    .speed_cmd(speed_cmd), .actual_speed(actual_speed),
    .power_limit(power_limit), .active_interface(active_interface),
    .set_speed_attained_flag(set_speed_attained_flag),
    .speed_range_warning(speed_range_warning),
    .runup_error(runup_error), .ctrl_out(ctrl_out));

// ==== verification/pdsc_drive_model.sv ====
// Purpose: motor drive model on the far side of the block
// Assumes: rotor follows the command one step per clock
// Notes: light gas load, so no overload trim is provoked
module pdsc_drive_model (
    input wire logic core_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic [9:0] speed_cmd, // commanded speed
    input wire logic [9:0] power_limit, // power ceiling
    output logic [9:0] actual_speed, // rotor speed
    output logic [9:0] power_in, // drawn power
    output logic [9:0] current_in // drawn current
);
    // rotor ramps toward the command
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            actual_speed <= 10'h000;
        end else if (actual_speed < speed_cmd) begin
            actual_speed <= actual_speed + 10'h001;
        end else if (actual_speed > speed_cmd) begin
            actual_speed <= actual_speed - 10'h001;
        end
    end
    // load held at half the ceiling
    assign power_in = power_limit >> 1;
    assign current_in = power_in;
endmodule

// ==== verification/pump_drive_speed_config_tb.sv ====
// Purpose: self-checking bench of the speed configuration block
// Assumes: short second and trim counts through parameters
// Notes: register port driven on rising edges
module pump_drive_speed_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, reg_we = 0, reg_re = 0;
    logic [7:0] reg_addr = 8'h00, ctrl_out;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [2:0] remote_din = 3'h0;
    logic [9:0] ai = 10'h155, analog_out, speed_cmd, power_limit;
    logic [9:0] actual_speed, power_in, current_in;
    logic [4:0] active_interface;
    logic sw_out, attained, warn, runup_error;
    int n_fail = 0, check_count = 0;
    pdsc_core #(.SEC_CYCLES(20), .ADJ_CYCLES(4)) dut (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .remote_din(remote_din),
        .analog_input_one(ai), .actual_speed(actual_speed),
        .power_in(power_in), .current_in(current_in),
        .pressure_one(10'h011), .pressure_two(10'h022),
        .forevac_ctrl(10'h033), .analog_out(analog_out),
        .speed_cmd(speed_cmd), .power_limit(power_limit),
        .active_interface(active_interface), .switchpoint_out(sw_out),
        .set_speed_attained_flag(attained), .speed_range_warning(warn),
        .runup_error(runup_error), .ctrl_out(ctrl_out));
    pdsc_drive_model u_drive (.core_clk(core_clk), .resetn(resetn),
        .speed_cmd(speed_cmd), .power_limit(power_limit),
        .actual_speed(actual_speed), .power_in(power_in),
        .current_in(current_in));
    // clock of 5 ns
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // wait a few edges, then until the rotor meets the command
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        for (int i = 0; actual_speed !== speed_cmd; i++) begin
            if (i == 3000) begin
                n_fail++;
                close_out();
            end
            @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset();
        rd(8'h03, 16'h0001);
        rd(8'h0B, 16'h029B);
        rd(8'h05, 16'h0064);
        rd(8'h20, 16'h0000);
        wr(8'h05, 16'h0065);
        rd(8'h05, 16'h0064);
    endtask
    task automatic t_iface();
        logic [15:0] w [4] = '{16'h0002, 16'h0104, 16'h0008, 16'h0003};
        logic [4:0] e [4] = '{5'h02, 5'h04, 5'h04, 5'h04};
        for (int i = 0; i < 4; i++) begin
            wr(8'h03, w[i]);
            settle(3);
            chk({11'h000, active_interface}, {11'h000, e[i]});
        end
    endtask
    task automatic t_ao();
        logic [15:0] c [5] = '{16'h3, 16'h4, 16'h5, 16'h5, 16'h9};
        logic [9:0] e [5] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h2AA};
        for (int i = 0; i < 5; i++) begin
            if (i == 3) ai <= 10'h2AA;
            wr(8'h01, c[i]);
            settle(3);
            chk({6'h00, analog_out}, {6'h00, e[i]});
        end
    endtask
    task automatic t_runup();
        wr(8'h06, 16'h0001);
        wr(8'h0C, 16'h0011);
        for (int i = 0; runup_error !== 1'b1; i++) begin
            if (i == 500) begin
                n_fail++;
                close_out();
            end
            @(posedge core_clk);
        end
        wr(8'h0C, 16'h0000);
        settle(4);
        chk({15'h0000, runup_error}, 16'h0000);
    endtask
    task automatic t_speed();
        wr(8'h04, 16'h0001);
        wr(8'h0C, 16'h0041);
        settle(4);
        chk({6'h00, speed_cmd}, 16'h029B);
        chk({6'h00, power_limit}, 16'h0352);
        rd(8'h0D, 16'h0002);
        wr(8'h0A, 16'h01F4);
        wr(8'h0C, 16'h0061);
        settle(4);
        chk({6'h00, speed_cmd}, 16'h01F4);
        chk({14'h0000, sw_out, attained}, 16'h0003);
        wr(8'h0A, 16'h0064);
        settle(4);
        chk({5'h00, warn, speed_cmd}, 16'h04C8);
        wr(8'h00, 16'h0002);
        remote_din <= 3'h1;
        settle(4);
        chk({15'h0000, ctrl_out[1]}, 16'h0001);
        wr(8'h0C, 16'h0000);
        settle(4);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        chk({6'h00, power_limit}, 16'h03E8);
        t_reset();
        t_iface();
        t_ao();
        t_runup();
        t_speed();
        close_out();
    end
endmodule
